// *** logic/cap_defines.svh ***
`ifndef CAP_DEFINES_SVH
`define CAP_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CAP_OFS_PROG_PAGE   8'h00
`define CAP_OFS_RAM_PAGE    8'h04
`define CAP_OFS_EEP_PAGE    8'h08
`define CAP_OFS_MAP_CTL     8'h0c
`define CAP_OFS_LAST_XLATE  8'h10

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CAP_CTL_HIMAP_BIT   0
`define CAP_PROG_PAGE_RST   8'hfe
`define CAP_RAM_PAGE_RST    8'hfd
`define CAP_EEP_PAGE_RST    8'hfe
`define CAP_MAP_CTL_RST     8'h00
`define CAP_INT_FIRST_DEF   248

// ----------------------------------------
// Global address bases
// ----------------------------------------
`define CAP_G_PROG_BASE     23'h40_0000
`define CAP_G_FIX_BASE      23'h7f_0000
`define CAP_G_HIMAP_BASE    23'h14_4000
`define CAP_G_RAM_BASE      23'h00_0000
`define CAP_G_EEP_BASE      23'h10_0000

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define CAP_RESP_OKAY       2'h0
`define CAP_RESP_DECERR     2'h3

`endif

// *** logic/cap_pkg.sv ***
package cap_pkg;

  typedef logic [22:0] cap_gaddr_t;
  typedef logic [7:0]  cap_page_t;

  // ----------------------------------------
  // Local window kinds
  // ----------------------------------------
  typedef enum logic [2:0] {
    CAP_WIN_FIXED = 3'h0,
    CAP_WIN_EEP   = 3'h1,
    CAP_WIN_RAM   = 3'h2,
    CAP_WIN_HIMAP = 3'h3,
    CAP_WIN_PROG  = 3'h4,
    CAP_WIN_TOP   = 3'h5
  } cap_win_e;

  function automatic cap_win_e cap_decode(input logic [15:0] a);
    cap_win_e w;
    w = CAP_WIN_FIXED;
    if (a[15:14] == 2'h3) begin
      w = CAP_WIN_TOP;
    end else if (a[15:14] == 2'h2) begin
      w = CAP_WIN_PROG;
    end else if (a[15:14] == 2'h1) begin
      w = CAP_WIN_HIMAP;
    end else if (a[15:12] == 4'h1) begin
      w = CAP_WIN_RAM;
    end else if (a[15:10] == 6'h02) begin
      w = CAP_WIN_EEP;
    end
    return w;
  endfunction : cap_decode

endpackage : cap_pkg

// *** logic/cap_top.sv ***
// Functional notes
// - Eight-bit program page picks one of 256 16K blocks at 0x8000-0xBFFF.
// - Program page is bus readable, writable, and loaded by paged call and return.
// - 0x4000-0x7FFF goes internal to 0x7F_4000 or, high-map set, external 0x14_4000.
// - Program window lands in 0x40_0000-0x7F_FFFF; on-chip size picks internal or external.
// - 0xC000-0xFFFF is unpaged, always 0x7F_C000-0x7F_FFFF, never external.
// - Eight-bit RAM page maps 4K blocks into 0x1000-0x1FFF.
// - Eight-bit EEPROM page maps 1K blocks into window from 0x0800.
// - Registers, vectors and fixed memory sit in unpaged space, untouched by pages.
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "cap_defines.svh"

module cap_top #(
  parameter int ADDR_W         = 8,
  parameter int INT_PAGE_FIRST = `CAP_INT_FIRST_DEF
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic [ADDR_W-1:0]  s_awaddr,
  input  wire logic               s_awvalid,
  output      logic               s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output      logic               s_wready,
  output      logic [1:0]         s_bresp,
  output      logic               s_bvalid,
  input  wire logic               s_bready,
  input  wire logic [ADDR_W-1:0]  s_araddr,
  input  wire logic               s_arvalid,
  output      logic               s_arready,
  output      logic [31:0]        s_rdata,
  output      logic [1:0]         s_rresp,
  output      logic               s_rvalid,
  input  wire logic               s_rready,
  input  wire logic               core_req,
  input  wire logic [15:0]        core_addr,
  input  wire logic               page_call_load,
  input  wire logic               page_return_load,
  input  wire cap_pkg::cap_page_t page_value,
  output      logic               xl_valid,
  output      cap_pkg::cap_gaddr_t xl_global,
  output      logic               xl_external
);
  import cap_pkg::*;

  // The decoder always looks at bits 7:2, so narrower buses cannot be served
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_aw
    $error("cap_top: ADDR_W must be 8 to 32");
  end
  if (INT_PAGE_FIRST < 0 || INT_PAGE_FIRST > 256) begin : g_bad_first
    $error("cap_top: INT_PAGE_FIRST must be 0 to 256");
  end

  // ----------------------------------------
  // Register bus write path
  // ----------------------------------------
  logic              awready_q, wready_q, bvalid_q, aw_hold_q, w_hold_q;
  logic [1:0]        bresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic              wstrb0_q;
  cap_page_t         prog_page_q, ram_page_q, eep_page_q, map_ctl_q;

  wire               aw_take  = s_awvalid & awready_q;
  wire               w_take   = s_wvalid & wready_q;
  wire               aw_have  = aw_hold_q | aw_take;
  wire               w_have   = w_hold_q | w_take;
  wire               do_write = aw_have & w_have & ~bvalid_q;
  wire [ADDR_W-1:0]  wr_addr  = aw_take ? s_awaddr : awaddr_q;
  wire [7:0]         wr_ofs   = {wr_addr[7:2], 2'h0};
  wire [31:0]        wr_data  = w_take ? s_wdata : wdata_q;
  wire               wr_lane0 = w_take ? s_wstrb[0] : wstrb0_q;
  wire               wr_hi_ok = (wr_addr >> 8) == '0;
  wire               wr_pp    = do_write & wr_hi_ok & (wr_ofs == `CAP_OFS_PROG_PAGE);
  wire               wr_rp    = do_write & wr_hi_ok & (wr_ofs == `CAP_OFS_RAM_PAGE);
  wire               wr_ep    = do_write & wr_hi_ok & (wr_ofs == `CAP_OFS_EEP_PAGE);
  wire               wr_mc    = do_write & wr_hi_ok & (wr_ofs == `CAP_OFS_MAP_CTL);
  wire               wr_map   = wr_pp | wr_rp | wr_ep | wr_mc;
  wire               aw_hold_d = aw_have & ~do_write;
  wire               w_hold_d  = w_have & ~do_write;
  wire               bvalid_d  = do_write | (bvalid_q & ~s_bready);
  // The core's paged call/return beats a bus write landing in the same cycle
  wire               core_load = page_call_load | page_return_load;
  wire cap_page_t    prog_page_d = core_load ? page_value :
                                   (wr_pp & wr_lane0) ? wr_data[7:0] : prog_page_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CAP_RESP_OKAY;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
    end else if (ce) begin
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      if (aw_take) begin
        awaddr_q <= s_awaddr;
      end
      if (w_take) begin
        wdata_q  <= s_wdata;
        wstrb0_q <= s_wstrb[0];
      end
      if (do_write) begin
        bresp_q <= wr_map ? `CAP_RESP_OKAY : `CAP_RESP_DECERR;
      end
    end
  end

  // ----------------------------------------
  // Page and control registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prog_page_q <= `CAP_PROG_PAGE_RST;
      ram_page_q  <= `CAP_RAM_PAGE_RST;
      eep_page_q  <= `CAP_EEP_PAGE_RST;
      map_ctl_q   <= `CAP_MAP_CTL_RST;
    end else if (ce) begin
      prog_page_q <= prog_page_d;
      if (wr_rp & wr_lane0) begin
        ram_page_q <= wr_data[7:0];
      end
      if (wr_ep & wr_lane0) begin
        eep_page_q <= wr_data[7:0];
      end
      if (wr_mc & wr_lane0) begin
        // Only the high-map select is implemented; other bits read zero
        map_ctl_q <= {7'h00, wr_data[`CAP_CTL_HIMAP_BIT]};
      end
    end
  end

  // ----------------------------------------
  // Address translation
  // ----------------------------------------
  cap_gaddr_t xg;
  logic       xe;
  cap_win_e   xw;
  logic       xl_valid_q, xl_external_q;
  cap_gaddr_t xl_global_q;

  cap_xlate #(
    .INT_PAGE_FIRST (INT_PAGE_FIRST)
  ) u_xlate (
    .local_addr  (core_addr),
    .prog_page   (prog_page_q),
    .ram_page    (ram_page_q),
    .eep_page    (eep_page_q),
    .himap       (map_ctl_q[`CAP_CTL_HIMAP_BIT]),
    .global_addr (xg),
    .external    (xe),
    .window      ()
  );
  assign xw = cap_decode(core_addr);

  // One cycle of latency buys a flop-driven address; result stands until next request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xl_valid_q    <= 1'b0;
      xl_global_q   <= '0;
      xl_external_q <= 1'b0;
    end else if (ce) begin
      xl_valid_q <= core_req;
      if (core_req) begin
        xl_global_q   <= xg;
        xl_external_q <= xe;
      end
    end
  end

  // ----------------------------------------
  // Register bus read path
  // ----------------------------------------
  logic        arready_q, rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  wire         ar_take  = s_arvalid & arready_q;
  wire [7:0]   rd_ofs   = {s_araddr[7:2], 2'h0};
  wire         rd_hi_ok = (s_araddr >> 8) == '0;
  wire         rvalid_d = ar_take | (rvalid_q & ~s_rready);
  wire         rd_hit   = rd_hi_ok & (rd_ofs <= `CAP_OFS_LAST_XLATE);
  logic [31:0] rd_word;

  always_comb begin
    unique case (rd_ofs)
      `CAP_OFS_PROG_PAGE:  rd_word = {24'h000000, prog_page_q};
      `CAP_OFS_RAM_PAGE:   rd_word = {24'h000000, ram_page_q};
      `CAP_OFS_EEP_PAGE:   rd_word = {24'h000000, eep_page_q};
      `CAP_OFS_MAP_CTL:    rd_word = {24'h000000, map_ctl_q};
      `CAP_OFS_LAST_XLATE: rd_word = {8'h00, xl_external_q, xl_global_q};
      default:             rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `CAP_RESP_OKAY;
      rdata_q   <= '0;
    end else if (ce) begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_hit ? rd_word : 32'h00000000;
        rresp_q <= rd_hit ? `CAP_RESP_OKAY : `CAP_RESP_DECERR;
      end
    end
  end

  assign s_awready   = awready_q;
  assign s_wready    = wready_q;
  assign s_bvalid    = bvalid_q;
  assign s_bresp     = bresp_q;
  assign s_arready   = arready_q;
  assign s_rvalid    = rvalid_q;
  assign s_rdata     = rdata_q;
  assign s_rresp     = rresp_q;
  assign xl_valid    = xl_valid_q;
  assign xl_global   = xl_global_q;
  assign xl_external = xl_external_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic        chk_live_q, chk_hm_q;
  logic [15:0] chk_addr_q;
  cap_page_t   chk_pp_q, chk_rp_q, chk_ep_q;
  cap_win_e    chk_win_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_live_q <= 1'b0;
      chk_hm_q   <= 1'b0;
      chk_addr_q <= '0;
      chk_pp_q   <= '0;
      chk_rp_q   <= '0;
      chk_ep_q   <= '0;
      chk_win_q  <= CAP_WIN_FIXED;
    end else if (ce) begin
      chk_live_q <= core_req;
      chk_hm_q   <= map_ctl_q[0];
      chk_addr_q <= core_addr;
      chk_pp_q   <= prog_page_q;
      chk_rp_q   <= ram_page_q;
      chk_ep_q   <= eep_page_q;
      chk_win_q  <= xw;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_call_seen;
    ce && page_call_load;
  endsequence
  sequence s_return_seen;
    ce && page_return_load;
  endsequence
  sequence s_page_taken;
    ##1 prog_page_q == $past(page_value);
  endsequence

  prog_global_a: assert property (chk_live_q && chk_win_q == CAP_WIN_PROG |->
      xl_valid_q && xl_global_q == 23'h40_0000 + chk_pp_q * 23'h4000 + chk_addr_q[13:0])
    else $error("program window address wrong");
  prog_block_a: assert property (chk_live_q && chk_win_q == CAP_WIN_PROG |->
      xl_global_q[21:14] == chk_pp_q && chk_addr_q[15:14] == 2'h2)
    else $error("program page not selecting block");
  call_load_a: assert property (s_call_seen |-> s_page_taken)
    else $error("paged call did not load page");
  return_load_a: assert property (s_return_seen |-> s_page_taken)
    else $error("paged return did not restore page");
  himap_map_a: assert property (chk_live_q && chk_win_q == CAP_WIN_HIMAP |->
      (chk_hm_q ? (xl_external_q && xl_global_q == 23'h14_0000 + chk_addr_q)
                : (!xl_external_q && xl_global_q == 23'h7f_0000 + chk_addr_q)))
    else $error("high-map window wrong");
  prog_ext_a: assert property (chk_live_q && chk_win_q == CAP_WIN_PROG |->
      xl_external_q == (chk_pp_q < INT_PAGE_FIRST) && xl_global_q >= 23'h40_0000)
    else $error("program external select wrong");
  top_fixed_a: assert property (chk_live_q && chk_addr_q >= 16'hc000 |->
      !xl_external_q && xl_global_q == 23'h7f_0000 + chk_addr_q)
    else $error("top region not fixed");
  ram_page_a: assert property (chk_live_q && chk_addr_q[15:12] == 4'h1 |->
      xl_global_q == chk_rp_q * 23'h1000 + chk_addr_q[11:0] && !xl_external_q)
    else $error("ram window wrong");
  eep_page_a: assert property (chk_live_q && chk_addr_q[15:10] == 6'h02 |->
      xl_global_q == 23'h10_0000 + chk_ep_q * 23'h400 + chk_addr_q[9:0])
    else $error("eeprom window wrong");
  unpaged_low_a: assert property (chk_live_q && chk_win_q == CAP_WIN_FIXED |->
      xl_global_q == 23'h7f_0000 + chk_addr_q && !xl_external_q)
    else $error("unpaged region moved by a page");
  bus_resp_a: assert property (ce && do_write |=> s_bvalid ##0 !s_awready && !s_wready)
    else $error("write response missing");

endmodule : cap_top

// *** logic/cap_xlate.sv ***
`timescale 1ns/100ps
`include "cap_defines.svh"

module cap_xlate #(
  parameter int INT_PAGE_FIRST = `CAP_INT_FIRST_DEF
) (
  input  wire logic [15:0]        local_addr,
  input  wire cap_pkg::cap_page_t prog_page,
  input  wire cap_pkg::cap_page_t ram_page,
  input  wire cap_pkg::cap_page_t eep_page,
  input  wire logic               himap,
  output      cap_pkg::cap_gaddr_t global_addr,
  output      logic               external,
  output      cap_pkg::cap_win_e  window
);
  import cap_pkg::*;

  localparam logic [8:0] INT_FIRST = 9'(INT_PAGE_FIRST);

  wire cap_gaddr_t g_fix   = `CAP_G_FIX_BASE | {7'h00, local_addr};
  wire cap_gaddr_t g_prog  = `CAP_G_PROG_BASE | {1'b0, prog_page, local_addr[13:0]};
  wire cap_gaddr_t g_himap = `CAP_G_HIMAP_BASE | {9'h000, local_addr[13:0]};
  wire cap_gaddr_t g_ram   = `CAP_G_RAM_BASE | {3'h0, ram_page, local_addr[11:0]};
  wire cap_gaddr_t g_eep   = `CAP_G_EEP_BASE | {5'h00, eep_page, local_addr[9:0]};
  // Pages below the first on-chip page fall off chip
  wire             prog_ext = ({1'b0, prog_page} < INT_FIRST);

  assign window = cap_decode(local_addr);

  // ----------------------------------------
  // Window selection
  // ----------------------------------------
  always_comb begin
    unique case (window)
      CAP_WIN_TOP: begin
        global_addr = g_fix;
        external    = 1'b0;
      end
      CAP_WIN_PROG: begin
        global_addr = g_prog;
        external    = prog_ext;
      end
      CAP_WIN_HIMAP: begin
        global_addr = himap ? g_himap : g_fix;
        external    = himap;
      end
      CAP_WIN_RAM: begin
        global_addr = g_ram;
        external    = 1'b0;
      end
      CAP_WIN_EEP: begin
        global_addr = g_eep;
        external    = 1'b0;
      end
      default: begin
        // Registers, vectors and fixed memory ignore every page
        global_addr = g_fix;
        external    = 1'b0;
      end
    endcase
  end

endmodule : cap_xlate

// *** sim/cap_core_model.sv ***
`timescale 1ns/100ps
// --------
// Core side: local fetches and paged call/return loads
// --------
module cap_core_model (
  input  wire logic               aclk,
  output      logic               core_req,
  output      logic [15:0]        core_addr,
  output      logic               page_call_load,
  output      logic               page_return_load,
  output      cap_pkg::cap_page_t page_value
);
  import cap_pkg::*;
  initial begin
    core_req = 1'b0;
    core_addr = 16'h5a5a;
    page_call_load = 1'b0;
    page_return_load = 1'b0;
    page_value = 8'ha5;
  end
  // Released lines flip so a stale value is never mistaken for a live one
  task automatic fetch(input logic [15:0] a);
    @(posedge aclk);
    core_req <= 1'b1;
    core_addr <= a;
    @(posedge aclk);
    core_req <= 1'b0;
    core_addr <= ~a;
  endtask : fetch
  // Handler entry taken from the top unpaged block, so no page is trusted
  task automatic vector_fetch();
    fetch(16'hfffe);
  endtask : vector_fetch
  task automatic page_load(input logic ret, input cap_page_t v);
    @(posedge aclk);
    page_call_load <= !ret;
    page_return_load <= ret;
    page_value <= v;
    @(posedge aclk);
    page_call_load <= 1'b0;
    page_return_load <= 1'b0;
    page_value <= ~v;
  endtask : page_load
endmodule : cap_core_model

// *** sim/cap_top_tb.sv ***
`timescale 1ns/100ps
`include "cap_defines.svh"
module cap_top_tb;
  import cap_pkg::*;
  localparam int INT_FIRST = `CAP_INT_FIRST_DEF;
  localparam logic [15:0] ADDRS [14] = '{16'h0000, 16'h07ff, 16'h0800, 16'h0bff, 16'h0c00,
    16'h1000, 16'h1fff, 16'h2000, 16'h4000, 16'h7fff, 16'h8000, 16'hbfff, 16'hc000, 16'hffff};
  logic        aclk, aresetn, ce, hm;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, last_q;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic        core_req, page_call_load, page_return_load, xl_valid, xl_external;
  logic [15:0] core_addr;
  cap_page_t   page_value, pp, rp, ep;
  cap_gaddr_t  xl_global;
  int          num_errors, total_checks, cyc;

  cap_top #(.ADDR_W(8), .INT_PAGE_FIRST(INT_FIRST)) dut (.aclk, .aresetn, .ce, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid,
    .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .core_req, .core_addr, .page_call_load, .page_return_load, .page_value, .xl_valid,
    .xl_global, .xl_external);
  cap_core_model core (.aclk, .core_req, .core_addr, .page_call_load, .page_return_load,
    .page_value);

  // --------
  // Checking and closing
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // A hang costs at most a few thousand cycles; the tests need well under that
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      print_verdict();
    end
  end

  // --------
  // Register bus master
  // --------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wstrb <= s;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    chk({30'h0, s_bresp}, {30'h0, er});
    s_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    chk(s_rdata, ed);
    chk({30'h0, s_rresp}, {30'h0, er});
    s_rready <= 1'b0;
  endtask : axr
  task automatic wr_reg(input logic [7:0] a, input cap_page_t v);
    axw(a, {24'hffffff, v}, 4'hf, `CAP_RESP_OKAY);
    case (a)
      `CAP_OFS_PROG_PAGE: pp = v;
      `CAP_OFS_RAM_PAGE:  rp = v;
      `CAP_OFS_EEP_PAGE:  ep = v;
      default:            hm = v[0];
    endcase
    axr(a, (a == `CAP_OFS_MAP_CTL) ? {31'h0, hm} : {24'h0, v}, `CAP_RESP_OKAY);
  endtask : wr_reg

  // --------
  // Translation expectations
  // --------
  function automatic cap_gaddr_t exp_g(input logic [15:0] a);
    if (a[15:14] == 2'h2) return {1'b1, pp, a[13:0]};
    if (a[15:14] == 2'h1 && hm) return 23'h14_0000 + {7'h0, a};
    if (a[15:12] == 4'h1) return {3'h0, rp, a[11:0]};
    if (a[15:10] == 6'h02) return 23'h10_0000 + {5'h0, ep, a[9:0]};
    return 23'h7f_0000 + {7'h0, a};
  endfunction : exp_g
  task automatic xl(input logic [15:0] a);
    logic e;
    e = (a[15:14] == 2'h2) ? (int'(pp) < INT_FIRST) : (a[15:14] == 2'h1) && hm;
    core.fetch(a);
    #1;
    chk({31'h0, xl_valid}, 32'h1);
    chk({9'h0, xl_global}, {9'h0, exp_g(a)});
    // Bus choice in the paged data windows is left open, so only the address counts there
    if (a[15:12] != 4'h1 && a[15:10] != 6'h02) chk({31'h0, xl_external}, {31'h0, e});
    last_q = {8'h0, e, exp_g(a)};
    @(posedge aclk);
    #1;
    chk({31'h0, xl_valid}, 32'h0);
  endtask : xl
  task automatic sweep();
    foreach (ADDRS[i]) xl(ADDRS[i]);
  endtask : sweep

  // --------
  // Main sequence
  // --------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    ce = 1'b1;
    cyc = 0;
    {pp, rp, ep, hm} = {8'hfe, 8'hfd, 8'hfe, 1'b0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`CAP_OFS_PROG_PAGE, 32'hfe, `CAP_RESP_OKAY);
    axr(`CAP_OFS_RAM_PAGE, 32'hfd, `CAP_RESP_OKAY);
    axr(`CAP_OFS_EEP_PAGE, 32'hfe, `CAP_RESP_OKAY);
    axr(`CAP_OFS_MAP_CTL, 32'h0, `CAP_RESP_OKAY);
    sweep();
    wr_reg(`CAP_OFS_PROG_PAGE, 8'h00);
    wr_reg(`CAP_OFS_RAM_PAGE, 8'h12);
    wr_reg(`CAP_OFS_EEP_PAGE, 8'hff);
    wr_reg(`CAP_OFS_MAP_CTL, 8'hff);
    sweep();
    foreach (ADDRS[i]) begin
      if (i < 3) begin
        wr_reg(`CAP_OFS_PROG_PAGE, (i == 0) ? 8'd247 : (i == 1) ? 8'd248 : 8'hff);
        xl(16'h8123);
        xl(16'hc123);
      end
    end
    core.page_load(1'b0, 8'h01);
    pp = 8'h01;
    axr(`CAP_OFS_PROG_PAGE, 32'h01, `CAP_RESP_OKAY);
    xl(16'h8123);
    axr(`CAP_OFS_LAST_XLATE, last_q, `CAP_RESP_OKAY);
    core.page_load(1'b1, 8'hf9);
    pp = 8'hf9;
    axr(`CAP_OFS_PROG_PAGE, 32'hf9, `CAP_RESP_OKAY);
    axw(`CAP_OFS_PROG_PAGE, 32'h33, 4'he, `CAP_RESP_OKAY);
    axr(`CAP_OFS_PROG_PAGE, 32'hf9, `CAP_RESP_OKAY);
    axw(`CAP_OFS_LAST_XLATE, 32'h0, 4'hf, `CAP_RESP_DECERR);
    axw(8'h20, 32'h5, 4'hf, `CAP_RESP_DECERR);
    axr(8'h14, 32'h0, `CAP_RESP_DECERR);
    // Clock enable low: a request must leave the last translation untouched
    @(posedge aclk);
    ce <= 1'b0;
    core.fetch(16'hc000);
    #1;
    chk({31'h0, xl_valid}, 32'h0);
    chk({9'h0, xl_global}, {9'h0, last_q[22:0]});
    @(posedge aclk);
    ce <= 1'b1;
    core.vector_fetch();
    #1;
    chk({9'h0, xl_global}, 32'h7f_fffe);
    print_verdict();
  end
endmodule : cap_top_tb
